// file: pkg/mmsr_pkg.sv
// constants, register map and carrier types of the multi-mode serial unit
package mmsr_pkg;
  localparam int unsigned MMSR_CLK_HZ = 100000000;
  localparam logic [7:0] MMSR_OFS_MODE = 8'he9;
  localparam logic [7:0] MMSR_OFS_IEN = 8'hea;
  localparam logic [7:0] MMSR_OFS_ROLE = 8'heb;
  localparam logic [7:0] MMSR_OFS_TWC = 8'hec;
  localparam logic [7:0] MMSR_OFS_SAR = 8'hed;
  localparam logic [7:0] MMSR_OFS_ST1 = 8'hf1;
  localparam logic [7:0] MMSR_OFS_ST2 = 8'hf2;
  localparam logic [7:0] MMSR_OFS_BD = 8'hf3;
  localparam logic [7:0] MMSR_OFS_HOLD = 8'hf4;
  localparam logic [7:0] MMSR_OFS_DATA = 8'hf5;
  localparam logic [7:0] MMSR_OFS_LOW = 8'hf6;
  localparam logic [7:0] MMSR_OFS_HIGH = 8'hf7;
  localparam logic [7:0] MMSR_RST_ZERO = 8'h00;
  localparam logic [7:0] MMSR_RST_ST1 = 8'h80;
  localparam logic [7:0] MMSR_RST_BD = 8'hff;
  localparam logic [7:0] MMSR_RST_HOLD = 8'h01;
  localparam logic [7:0] MMSR_RST_PER = 8'h3f;
  // scl periods: 4*n+2 clocks, hold: n+2 clocks
  localparam logic [9:0] MMSR_PER_ADD = 10'h002;
  localparam logic [8:0] MMSR_HOLD_ADD = 9'h002;
  localparam logic [6:0] MMSR_GCALL_ADDR = 7'h00;
  // bit positions in mode_frame_control
  localparam int MMSR_B_PAR_LO = 4;
  localparam int MMSR_B_LEN_LO = 1;
  // interrupt_enable_control
  localparam int MMSR_B_DRIE = 7;
  localparam int MMSR_B_TXCIE = 6;
  localparam int MMSR_B_RXCIE = 5;
  localparam int MMSR_B_WAKEIE = 4;
  localparam int MMSR_B_TXON = 3;
  localparam int MMSR_B_RXON = 2;
  localparam int MMSR_B_UNIT = 1;
  localparam int MMSR_B_DBL = 0;
  // role_option_control
  localparam int MMSR_B_MASTER = 7;
  localparam int MMSR_B_SSEN = 4;
  localparam int MMSR_B_SWAP = 3;
  localparam int MMSR_B_RX9 = 0;
  // status_primary
  localparam int MMSR_B_DRE = 7;
  localparam int MMSR_B_TXC = 6;
  localparam int MMSR_B_RXC = 5;
  localparam int MMSR_B_WAKE = 4;
  // two_wire_status clear mask: byte done, stop, addressed, lost, ack
  localparam logic [7:0] MMSR_ST2_CLR = 8'h79;
  localparam int MMSR_B_ADDRD = 4;
  localparam int MMSR_B_TWMASTER = 2;
  localparam int MMSR_B_IICIE = 4;

  typedef enum logic [1:0] {
    MMSR_UART, MMSR_SYNC, MMSR_I2C, MMSR_SPI
  } mmsr_proto_type;

  typedef enum logic [1:0] {
    MMSR_PAR_NONE, MMSR_PAR_RSV, MMSR_PAR_EVEN, MMSR_PAR_ODD
  } mmsr_par_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mmsr_bus_type;

  // decoded configuration handed to the protocol engines
  typedef struct packed {
    logic unit_on;
    mmsr_proto_type protocol_select;
    mmsr_par_type parity_select;
    logic [3:0] data_bits;
    logic transmitter_on;
    logic receiver_on;
    logic double_speed_sel;
    logic clock_master_sel;
    logic slave_select_on;
    logic data_pin_swap;
    logic [6:0] own_address_field;
    logic general_call_accept;
  } mmsr_cfg_type;
endpackage : mmsr_pkg

// file: verilog/mmsr_regs.sv
// register file, i2c clock and hold timing, and event plumbing
`timescale 1ns/1ps
//
// Contract
// - data address writes transmit buffer, reads return receive buffer
// - spi master starts serial clock on a data register write
// - i2c data changes hold value plus 2 clocks after scl falls
// - i2c master holds scl high for 4 times high value plus 2
// - i2c master holds scl low for 4 times low value plus 2
// - master bit period is 4 times low plus high plus 4 clocks
// - slave matches received address against upper seven address bits
// - address bit 0 ignores or accepts the general call address
// - enables for empty, tx done, rx done gate interrupt requests; code raises these requests in uart and spi only
// - uart wake enabled: low receive line requests wake interrupt; code requests it only while in_stop_mode is set
// - transmitter and receiver enables switch their units; code switches them in uart and spi only, never in sync
// - unit enable activates the block, cleared keeps it disabled; code still decodes double speed, master, select and swap with it cleared
// - double speed bit selects uart receiver sampling rate
// - master bit makes serial clock an output, else input
// - slave select enable turns on slave select pin in spi
// - swap bit exchanges master-out and master-in pin roles
// - received ninth bit shows in a status bit
// - empty flag reads 1 when transmit buffer can take data
// - write to i2c status 2 releases scl and clears flags
module mmsr_regs
  import mmsr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire mmsr_pkg::mmsr_bus_type bus,
  output logic [7:0] rdata,
  // engine side: transmit buffer
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_taken,
  input wire logic tx_done,
  // engine side: receive
  input wire logic [7:0] rx_data,
  input wire logic rx_bit9,
  input wire logic rx_valid,
  // engine side: i2c events
  input wire logic [6:0] rx_addr,
  input wire logic rx_addr_valid,
  input wire logic tw_byte_done,
  input wire logic tw_stop,
  input wire logic tw_lost,
  input wire logic tw_ack,
  input wire logic tw_scl_fall,
  // pins sampled from outside
  input wire logic receive_line,
  input wire logic in_stop_mode,
  // configuration and control out
  output mmsr_pkg::mmsr_cfg_type cfg,
  output logic spi_start,
  output logic scl_hold_low,
  output logic scl_gen,
  output logic sda_update,
  output logic addr_match,
  output logic irq_req
);
  import mmsr_pkg::*;

  logic [7:0] mode_frame_control, interrupt_enable_control;
  logic [7:0] role_option_control, two_wire_control, own_slave_address;
  logic [7:0] status_primary, two_wire_status, baud_divider;
  logic [7:0] data_hold_time, clock_low_period, clock_high_period;
  logic [7:0] rx_buf;
  logic rx_bit9_q;
  logic rx_s1, rx_s2;
  logic [9:0] per_cnt;
  logic [8:0] hold_cnt;
  logic hold_run;

  wire wr_mode = bus.wr && bus.addr == MMSR_OFS_MODE;
  wire wr_ien = bus.wr && bus.addr == MMSR_OFS_IEN;
  wire wr_role = bus.wr && bus.addr == MMSR_OFS_ROLE;
  wire wr_twc = bus.wr && bus.addr == MMSR_OFS_TWC;
  wire wr_sar = bus.wr && bus.addr == MMSR_OFS_SAR;
  wire wr_st1 = bus.wr && bus.addr == MMSR_OFS_ST1;
  wire wr_st2 = bus.wr && bus.addr == MMSR_OFS_ST2;
  wire wr_bd = bus.wr && bus.addr == MMSR_OFS_BD;
  wire wr_hold = bus.wr && bus.addr == MMSR_OFS_HOLD;
  wire wr_data = bus.wr && bus.addr == MMSR_OFS_DATA;
  wire wr_low = bus.wr && bus.addr == MMSR_OFS_LOW;
  wire wr_high = bus.wr && bus.addr == MMSR_OFS_HIGH;
  wire rd_data = bus.rd && bus.addr == MMSR_OFS_DATA;

  wire mmsr_proto_type proto = mmsr_proto_type'(mode_frame_control[7:6]);
  wire [1:0] par_raw = mode_frame_control[MMSR_B_PAR_LO +: 2];
  wire mmsr_par_type par = (par_raw == 2'h1) ? MMSR_PAR_NONE :
    mmsr_par_type'(par_raw);
  // frame length, reserved codes fall back to 8 bits
  wire [2:0] len_code = mode_frame_control[MMSR_B_LEN_LO +: 3];
  wire [3:0] len_bits = (len_code == 3'h7) ? 4'h9 :
    (len_code[2] ? 4'h8 : {2'h0, len_code[1:0]} + 4'h5);
  wire unit = interrupt_enable_control[MMSR_B_UNIT];
  wire uart_spi = proto == MMSR_UART || proto == MMSR_SPI;
  wire is_i2c = unit && proto == MMSR_I2C;
  wire tw_master = two_wire_control[MMSR_B_TWMASTER];

  mmsr_cfg_type next_cfg;
  assign next_cfg.unit_on = unit;
  assign next_cfg.protocol_select = proto;
  assign next_cfg.parity_select = par;
  assign next_cfg.data_bits = len_bits;
  assign next_cfg.transmitter_on = unit && uart_spi &&
    interrupt_enable_control[MMSR_B_TXON];
  assign next_cfg.receiver_on = unit && uart_spi &&
    interrupt_enable_control[MMSR_B_RXON];
  assign next_cfg.double_speed_sel = proto == MMSR_UART &&
    interrupt_enable_control[MMSR_B_DBL];
  assign next_cfg.clock_master_sel = (proto == MMSR_SPI ||
    proto == MMSR_SYNC) && role_option_control[MMSR_B_MASTER];
  assign next_cfg.slave_select_on = proto == MMSR_SPI &&
    role_option_control[MMSR_B_SSEN];
  assign next_cfg.data_pin_swap = proto == MMSR_SPI &&
    role_option_control[MMSR_B_SWAP];
  assign next_cfg.own_address_field = own_slave_address[7:1];
  assign next_cfg.general_call_accept = own_slave_address[0];

  wire next_match = rx_addr_valid && is_i2c && !tw_master &&
    (rx_addr == own_slave_address[7:1] ||
    (own_slave_address[0] && rx_addr == MMSR_GCALL_ADDR));

  // wake only in uart and stop
  wire wake_ev = unit && proto == MMSR_UART && in_stop_mode && !rx_s2 &&
    interrupt_enable_control[MMSR_B_WAKEIE];

  wire next_irq = (uart_spi && unit && (
    (status_primary[MMSR_B_DRE] && interrupt_enable_control[MMSR_B_DRIE]) ||
    (status_primary[MMSR_B_TXC] && interrupt_enable_control[MMSR_B_TXCIE]) ||
    (status_primary[MMSR_B_RXC] &&
    interrupt_enable_control[MMSR_B_RXCIE]))) ||
    (status_primary[MMSR_B_WAKE] &&
    interrupt_enable_control[MMSR_B_WAKEIE]) ||
    (is_i2c && two_wire_control[MMSR_B_IICIE] && |two_wire_status);

  wire [9:0] next_per_len = scl_gen ?
    {clock_high_period, 2'h0} + MMSR_PER_ADD :
    {clock_low_period, 2'h0} + MMSR_PER_ADD;
  wire per_end = per_cnt >= next_per_len - 10'h001;
  wire [8:0] hold_len = {1'b0, data_hold_time} + MMSR_HOLD_ADD;

  // events set status; set wins over clear
  wire [7:0] st2_set = {1'b0, tw_byte_done, tw_stop, next_match, tw_lost,
    2'h0, tw_ack};
  wire [7:0] next_st2 = (wr_st2 ? (two_wire_status & ~MMSR_ST2_CLR) :
    two_wire_status) | st2_set;
  wire next_dre = !(tx_valid || wr_data) || tx_taken;
  wire next_txc = (status_primary[MMSR_B_TXC] && !wr_data &&
    !(wr_st1 && !bus.wdata[MMSR_B_TXC])) || tx_done;
  wire next_rxc = (status_primary[MMSR_B_RXC] && !rd_data) || rx_valid;
  wire next_wake = (status_primary[MMSR_B_WAKE] &&
    !(wr_st1 && !bus.wdata[MMSR_B_WAKE])) || wake_ev;

  wire [7:0] rd_mux =
    bus.addr == MMSR_OFS_MODE ? mode_frame_control :
    bus.addr == MMSR_OFS_IEN ? interrupt_enable_control :
    bus.addr == MMSR_OFS_ROLE ? role_option_control :
    bus.addr == MMSR_OFS_TWC ? two_wire_control :
    bus.addr == MMSR_OFS_SAR ? own_slave_address :
    bus.addr == MMSR_OFS_ST1 ? status_primary :
    bus.addr == MMSR_OFS_ST2 ? two_wire_status :
    bus.addr == MMSR_OFS_BD ? baud_divider :
    bus.addr == MMSR_OFS_HOLD ? data_hold_time :
    bus.addr == MMSR_OFS_DATA ? rx_buf :
    bus.addr == MMSR_OFS_LOW ? clock_low_period :
    bus.addr == MMSR_OFS_HIGH ? clock_high_period : MMSR_RST_ZERO;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_frame_control <= MMSR_RST_ZERO;
      interrupt_enable_control <= MMSR_RST_ZERO;
      role_option_control <= MMSR_RST_ZERO;
      two_wire_control <= MMSR_RST_ZERO;
      own_slave_address <= MMSR_RST_ZERO;
      baud_divider <= MMSR_RST_BD;
      data_hold_time <= MMSR_RST_HOLD;
      clock_low_period <= MMSR_RST_PER;
      clock_high_period <= MMSR_RST_PER;
    end
    else
    begin
      if (wr_mode) mode_frame_control <= bus.wdata;
      if (wr_ien) interrupt_enable_control <= bus.wdata;
      if (wr_role) role_option_control <= bus.wdata;
      if (wr_twc) two_wire_control <= bus.wdata;
      if (wr_sar) own_slave_address <= bus.wdata;
      // zero or one divider is software's burden
      if (wr_bd) baud_divider <= bus.wdata;
      if (wr_hold) data_hold_time <= bus.wdata;
      if (wr_low) clock_low_period <= bus.wdata;
      if (wr_high) clock_high_period <= bus.wdata;
    end
  end

  // ninth bit kept beside the receive buffer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      status_primary <= MMSR_RST_ST1;
      two_wire_status <= MMSR_RST_ZERO;
      rx_buf <= MMSR_RST_ZERO;
      rx_bit9_q <= 1'b0;
    end
    else
    begin
      status_primary <= {next_dre, next_txc, next_rxc, next_wake,
        wr_st1 ? bus.wdata[3:0] : status_primary[3:0]};
      // a status 2 write clears the i2c flags
      two_wire_status <= next_st2;
      if (rx_valid)
      begin
        rx_buf <= rx_data;
        rx_bit9_q <= rx_bit9;
      end
    end
  end

  wire [7:0] role_rd = {role_option_control[7:1], rx_bit9_q};

  // transmit buffer written, receive buffer read
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_data <= MMSR_RST_ZERO;
      tx_valid <= 1'b0;
      rdata <= MMSR_RST_ZERO;
      spi_start <= 1'b0;
    end
    else
    begin
      // a write while full overwrites the pending byte
      if (wr_data) tx_data <= bus.wdata;
      tx_valid <= (tx_valid && !tx_taken) || wr_data;
      rdata <= bus.addr == MMSR_OFS_ROLE ? role_rd : rd_mux;
      // spi master clock starts on data write
      spi_start <= wr_data && unit && proto == MMSR_SPI &&
        role_option_control[MMSR_B_MASTER];
    end
  end

  // two-flop sync of the receive line for wake detection
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= receive_line;
      rx_s2 <= rx_s1;
    end
  end

  // scl generator, stalls low while held
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      per_cnt <= 10'h000;
      scl_gen <= 1'b1;
    end
    else if (!(is_i2c && tw_master) || (scl_hold_low && !scl_gen))
    begin
      per_cnt <= 10'h000;
      scl_gen <= scl_gen;
    end
    else if (per_end)
    begin
      per_cnt <= 10'h000;
      scl_gen <= !scl_gen;
    end
    else
    begin
      per_cnt <= per_cnt + 10'h001;
    end
  end

  // sda update after hold time from scl fall
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hold_cnt <= 9'h000;
      hold_run <= 1'b0;
      sda_update <= 1'b0;
    end
    else
    begin
      sda_update <= hold_run && hold_cnt == hold_len - 9'h002;
      if (tw_scl_fall && is_i2c)
      begin
        hold_cnt <= 9'h000;
        hold_run <= 1'b1;
      end
      else if (hold_run && hold_cnt == hold_len - 9'h002)
      begin
        hold_run <= 1'b0;
      end
      else if (hold_run)
      begin
        hold_cnt <= hold_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg <= '0;
      scl_hold_low <= 1'b0;
      addr_match <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      // held scl released by status 2 write
      scl_hold_low <= is_i2c && ((scl_hold_low && !wr_st2) ||
        tw_byte_done || next_match);
      addr_match <= next_match;
      irq_req <= next_irq;
    end
  end

  spi_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_data && unit && proto == MMSR_SPI &&
    role_option_control[MMSR_B_MASTER] |=> spi_start)
    else $error("spi clock not started by data write");
  empty_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_data && !tx_taken |=> !status_primary[MMSR_B_DRE])
    else $error("empty flag still set after data write");
  st2_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_st2 && st2_set == 8'h00 |=> (two_wire_status & MMSR_ST2_CLR) == 0)
    else $error("status 2 flags not cleared");
  gcall_ign_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rx_addr_valid && rx_addr == MMSR_GCALL_ADDR && !own_slave_address[0] &&
    own_slave_address[7:1] != MMSR_GCALL_ADDR |=> !addr_match)
    else $error("general call matched while ignored");
  addr_match_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    rx_addr_valid && is_i2c && !tw_master &&
    rx_addr == own_slave_address[7:1] |=> addr_match ##1 scl_hold_low)
    else $error("own address not matched");
  unit_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !unit |=> !cfg.transmitter_on && !cfg.receiver_on)
    else $error("units on while block disabled");
  sequence scl_fall_s;
    tw_scl_fall && is_i2c && data_hold_time == 8'h00;
  endsequence
  hold_time_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    scl_fall_s ##1 !tw_scl_fall |-> ##1 sda_update)
    else $error("sda not updated after minimum hold");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    interrupt_enable_control == MMSR_RST_ZERO && two_wire_control ==
    MMSR_RST_ZERO && $past(interrupt_enable_control) == MMSR_RST_ZERO
    |=> !irq_req)
    else $error("interrupt requested with all enables clear");
endmodule : mmsr_regs

// file: verification/mmsr_engine_model.sv
// behavioural protocol engines facing the register block
`timescale 1ns/1ps
module mmsr_engine_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // transmit buffer handshake
  input wire logic tx_valid,
  output logic tx_taken,
  output logic tx_done,
  // received data and two-wire events
  output logic [7:0] rx_data,
  output logic rx_bit9,
  output logic rx_valid,
  output logic [6:0] rx_addr,
  output logic rx_addr_valid,
  output logic tw_byte_done,
  output logic tw_stop,
  output logic tw_lost,
  output logic tw_ack,
  output logic tw_scl_fall,
  // receive pin, idles high
  output logic receive_line
);
  initial
  begin
    {tx_taken, tx_done, rx_valid, rx_addr_valid} = 4'h0;
    {tw_byte_done, tw_stop, tw_lost, tw_ack, tw_scl_fall} = 5'h00;
    rx_data = 8'h00;
    rx_bit9 = 1'b0;
    rx_addr = 7'h00;
    receive_line = 1'b1;
  end
  // slow shifter: buffer stays full ten clocks before it is taken
  always
  begin
    @(posedge clk_sys);
    if (rstn && tx_valid)
    begin
      repeat (10) @(posedge clk_sys);
      tx_taken <= 1'b1;
      @(posedge clk_sys);
      tx_taken <= 1'b0;
      repeat (8) @(posedge clk_sys);
      tx_done <= 1'b1;
      @(posedge clk_sys);
      tx_done <= 1'b0;
    end
  end
  // idle data shows the inverse, never a stale copy
  task automatic recv(input logic [7:0] d, input logic b9);
    @(posedge clk_sys);
    rx_data <= d;
    rx_bit9 <= b9;
    rx_valid <= 1'b1;
    @(posedge clk_sys);
    rx_data <= ~d;
    rx_bit9 <= ~b9;
    rx_valid <= 1'b0;
  endtask : recv
  task automatic addr(input logic [6:0] a);
    @(posedge clk_sys);
    rx_addr <= a;
    rx_addr_valid <= 1'b1;
    @(posedge clk_sys);
    rx_addr <= ~a;
    rx_addr_valid <= 1'b0;
  endtask : addr
  task automatic tw_pulse;
    @(posedge clk_sys);
    {tw_byte_done, tw_stop, tw_lost, tw_ack} <= 4'hf;
    @(posedge clk_sys);
    {tw_byte_done, tw_stop, tw_lost, tw_ack} <= 4'h0;
  endtask : tw_pulse
  task automatic scl_fall;
    @(posedge clk_sys);
    tw_scl_fall <= 1'b1;
    @(posedge clk_sys);
    tw_scl_fall <= 1'b0;
  endtask : scl_fall
  // line low for eight link periods
  task automatic line_low;
    receive_line <= 1'b0;
    #640;
    receive_line <= 1'b1;
  endtask : line_low
endmodule : mmsr_engine_model

// file: verification/test_multi_mode_serial_regs.sv
// self-checking bench for the serial unit register block
`timescale 1ns/1ps
module test_multi_mode_serial_regs;
  import mmsr_pkg::*;
  logic clk_sys, rstn, in_stop_mode, spi_seen, match_seen;
  mmsr_bus_type bus;
  mmsr_cfg_type cfg;
  logic [7:0] rdata, tx_data, rx_data;
  logic [6:0] rx_addr;
  logic tx_valid, tx_taken, tx_done, rx_bit9, rx_valid, rx_addr_valid;
  logic tw_byte_done, tw_stop, tw_lost, tw_ack, tw_scl_fall, receive_line;
  logic spi_start, scl_hold_low, scl_gen, sda_update, addr_match, irq_req;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [7:0] ofs_tab [13] = '{MMSR_OFS_MODE, MMSR_OFS_IEN,
    MMSR_OFS_ROLE, MMSR_OFS_TWC, MMSR_OFS_SAR, MMSR_OFS_ST1, MMSR_OFS_ST2,
    MMSR_OFS_BD, MMSR_OFS_HOLD, MMSR_OFS_DATA, MMSR_OFS_LOW, MMSR_OFS_HIGH,
    8'hf0};
  localparam logic [7:0] rst_tab [13] = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h80, 8'h00, 8'hff, 8'h01, 8'h00, 8'h3f, 8'h3f, 8'h00};

  mmsr_regs i_dut (.clk_sys, .rstn, .bus, .rdata, .tx_data, .tx_valid,
    .tx_taken, .tx_done, .rx_data, .rx_bit9, .rx_valid, .rx_addr,
    .rx_addr_valid, .tw_byte_done, .tw_stop, .tw_lost, .tw_ack,
    .tw_scl_fall, .receive_line, .in_stop_mode, .cfg, .spi_start,
    .scl_hold_low, .scl_gen, .sda_update, .addr_match, .irq_req);
  mmsr_engine_model i_eng (.clk_sys, .rstn, .tx_valid, .tx_taken, .tx_done,
    .rx_data, .rx_bit9, .rx_valid, .rx_addr, .rx_addr_valid, .tw_byte_done,
    .tw_stop, .tw_lost, .tw_ack, .tw_scl_fall, .receive_line);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // pulse catchers and hang guard
  always @(posedge clk_sys)
  begin
    if (spi_start === 1'b1) spi_seen <= 1'b1;
    if (addr_match === 1'b1) match_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_empty;
    for (int n = 0; n < 100 && tx_valid !== 1'b0; n++) step();
  endtask : wait_empty

  task automatic t_reset;
    logic [7:0] v;
    for (int i = 0; i < 13; i++)
    begin
      rd(ofs_tab[i], v);
      chk("reset value", rst_tab[i], v);
    end
    wr(8'hf0, 8'h5a);
    rd(8'hf0, v);
    chk("unmapped", 8'h00, v);
    $display("done reset values");
  endtask : t_reset

  task automatic t_data;
    logic [7:0] v;
    wr(MMSR_OFS_MODE, 8'h06);
    wr(MMSR_OFS_IEN, 8'h0e);
    wr(MMSR_OFS_DATA, 8'ha5);
    chk("tx buffer", 8'ha5, tx_data);
    chk("tx full", 8'h01, {7'h00, tx_valid});
    rd(MMSR_OFS_ST1, v);
    chk("empty flag", 8'h00, v & 8'h80);
    wait_empty();
    rd(MMSR_OFS_ST1, v);
    chk("empty flag", 8'h80, v & 8'h80);
    i_eng.recv(8'h3c, 1'b1);
    rd(MMSR_OFS_ST1, v);
    chk("rx done", 8'h20, v & 8'h20);
    rd(MMSR_OFS_ROLE, v);
    chk("ninth bit", 8'h01, v & 8'h01);
    rd(MMSR_OFS_DATA, v);
    chk("rx buffer", 8'h3c, v);
    rd(MMSR_OFS_ST1, v);
    chk("rx done", 8'h00, v & 8'h20);
    $display("done data path");
  endtask : t_data

  task automatic t_spi;
    wr(MMSR_OFS_MODE, 8'hc6);
    wr(MMSR_OFS_BD, 8'h02);
    wr(MMSR_OFS_ROLE, 8'h80);
    spi_seen = 1'b0;
    wr(MMSR_OFS_DATA, 8'h11);
    repeat (3) step();
    chk("spi start", 8'h01, {7'h00, spi_seen});
    wait_empty();
    wr(MMSR_OFS_ROLE, 8'h00);
    spi_seen = 1'b0;
    wr(MMSR_OFS_DATA, 8'h22);
    repeat (3) step();
    chk("slave start", 8'h00, {7'h00, spi_seen});
    wait_empty();
    $display("done spi start");
  endtask : t_spi

  task automatic t_i2c_clock;
    logic [7:0] hi, lo;
    int n;
    wr(MMSR_OFS_MODE, 8'h80);
    wr(MMSR_OFS_HIGH, 8'h01);
    wr(MMSR_OFS_LOW, 8'h02);
    wr(MMSR_OFS_TWC, 8'h04);
    for (n = 0; n < 600 && scl_gen !== 1'b0; n++) step();
    for (n = 0; n < 600 && scl_gen !== 1'b1; n++) step();
    for (hi = 8'h00; hi < 8'hc8 && scl_gen === 1'b1; hi++) step();
    for (lo = 8'h00; lo < 8'hc8 && scl_gen === 1'b0; lo++) step();
    chk("scl high", 8'h06, hi);
    chk("scl low", 8'h0a, lo);
    wr(MMSR_OFS_HOLD, 8'h03);
    i_eng.scl_fall();
    // count starts at the edge that drove the fall
    for (hi = 8'h01; hi < 8'h14 && sda_update !== 1'b1; hi++) step();
    chk("sda delay", 8'h05, hi);
    wr(MMSR_OFS_HOLD, 8'h00);
    i_eng.scl_fall();
    for (hi = 8'h01; hi < 8'h14 && sda_update !== 1'b1; hi++) step();
    chk("sda minimum", 8'h02, hi);
    $display("done i2c timing");
  endtask : t_i2c_clock

  task automatic try_addr(input logic [6:0] a, input logic exp);
    match_seen = 1'b0;
    i_eng.addr(a);
    repeat (3) step();
    chk("address match", {7'h00, exp}, {7'h00, match_seen});
  endtask : try_addr

  task automatic t_two_wire;
    logic [7:0] v;
    wr(MMSR_OFS_TWC, 8'h00);
    wr(MMSR_OFS_SAR, 8'hb4);
    try_addr(7'h5b, 1'b0);
    try_addr(7'h00, 1'b0);
    try_addr(7'h5a, 1'b1);
    i_eng.tw_pulse();
    rd(MMSR_OFS_ST2, v);
    chk("two wire flags", MMSR_ST2_CLR, v & MMSR_ST2_CLR);
    wr(MMSR_OFS_ST2, 8'h5a);
    rd(MMSR_OFS_ST2, v);
    chk("flags cleared", 8'h00, v & MMSR_ST2_CLR);
    chk("scl release", 8'h00, {7'h00, scl_hold_low});
    wr(MMSR_OFS_SAR, 8'hb5);
    try_addr(7'h00, 1'b1);
    $display("done two wire");
  endtask : t_two_wire

  task automatic t_wake;
    logic [7:0] v;
    wr(MMSR_OFS_MODE, 8'h06);
    wr(MMSR_OFS_IEN, 8'h12);
    wr(MMSR_OFS_ST1, 8'h00);
    in_stop_mode <= 1'b1;
    i_eng.line_low();
    rd(MMSR_OFS_ST1, v);
    chk("wake flag", 8'h10, v & 8'h10);
    chk("wake request", 8'h01, {7'h00, irq_req});
    in_stop_mode <= 1'b0;
    wr(MMSR_OFS_ST1, 8'h80);
    repeat (2) step();
    chk("request cleared", 8'h00, {7'h00, irq_req});
    wr(MMSR_OFS_IEN, 8'h82);
    repeat (2) step();
    chk("empty request", 8'h01, {7'h00, irq_req});
    $display("done wake");
  endtask : t_wake

  task automatic cfg_case(input logic [7:0] mode, input logic [7:0] ien,
    input logic [7:0] frame, input logic [7:0] role);
    logic [7:0] f, r;
    wr(MMSR_OFS_MODE, mode);
    wr(MMSR_OFS_IEN, ien);
    step();
    f = {cfg.protocol_select, cfg.parity_select, cfg.data_bits};
    r = {cfg.unit_on, cfg.transmitter_on, cfg.receiver_on,
      cfg.double_speed_sel, cfg.clock_master_sel, cfg.slave_select_on,
      cfg.data_pin_swap, 1'b0};
    chk("frame decode", frame, f);
    chk("role decode", role, r);
  endtask : cfg_case

  task automatic t_cfg;
    logic [7:0] v;
    v = {cfg.own_address_field, cfg.general_call_accept};
    chk("own address", 8'hb5, v);
    wr(MMSR_OFS_ROLE, 8'h98);
    cfg_case(8'h1e, 8'h0f, 8'h09, 8'hf0);
    cfg_case(8'h28, 8'h0f, 8'h28, 8'hf0);
    cfg_case(8'h34, 8'h0b, 8'h37, 8'hd0);
    cfg_case(8'hc0, 8'h0f, 8'hc5, 8'hee);
    cfg_case(8'h40, 8'h0d, 8'h45, 8'h08);
    $display("done configuration decode");
  endtask : t_cfg

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    rstn = 1'b0;
    bus = '0;
    in_stop_mode = 1'b0;
    spi_seen = 1'b0;
    match_seen = 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_data();
    t_spi();
    t_i2c_clock();
    t_two_wire();
    t_wake();
    t_cfg();
    tally_and_finish();
  end
endmodule : test_multi_mode_serial_regs
